// ===== obq_encoder.sv
// module: byte input, fifo, msb-first serializer, scrambler, differential qpsk
// encoder and root raised cosine shaping of the i and q impulses
// assumes bytes already carry fec; source honours byte_ready_out
`timescale 1ns/1ps
module obq_encoder (
    input  wire logic                 core_clk_in,
    input  wire logic                 reset_in,
    input  wire logic [7:0]           byte_in,
    input  wire logic                 byte_valid_in,
    output logic                      byte_ready_out,
    output logic                      scrambled_bit_out,
    output logic                      bit_valid_out,
    output logic                      underrun_out,
    output logic                      i_bit_out,
    output logic                      q_bit_out,
    output logic signed [1:0]         i_level_out,
    output logic signed [1:0]         q_level_out,
    output logic                      symbol_valid_out,
    output logic signed [11:0]        i_sample_out,
    output logic signed [11:0]        q_sample_out,
    output logic                      sample_valid_out
);
    localparam int NT = obq_pkg::NUM_TAPS;

    // timing
    logic [17:0]              acc;
    logic [17:0]              next_acc;
    logic                     sample_odd;
    logic                     next_sample_odd;
    logic                     sample_tick;
    logic                     bit_tick;
    // serializer, scrambler, pairing
    logic [7:0]               fifo_data;
    logic                     fifo_valid;
    logic                     fifo_pop;
    logic [7:0]               shreg;
    logic [7:0]               next_shreg;
    logic [2:0]               bit_cnt;
    logic [2:0]               next_bit_cnt;
    logic                     plain_bit;
    logic                     scr_bit;
    logic                     starved;
    logic [5:0]               sreg;
    logic [5:0]               next_sreg;
    obq_pkg::obq_pair_state_t pair_state;
    obq_pkg::obq_pair_state_t next_pair_state;
    logic                     lead_bit;
    logic                     next_lead_bit;
    logic [1:0]               phase;
    logic [1:0]               next_phase;
    logic                     sym_form;
    logic [1:0]               new_iq;
    // shaping filter
    logic [1:0]               taps [0:NT-1];
    logic [1:0]               next_taps [0:NT-1];
    logic signed [11:0]       i_sum;
    logic signed [11:0]       q_sum;

    obq_fifo #(
        .WIDTH (obq_pkg::FIFO_WIDTH),
        .DEPTH (obq_pkg::FIFO_DEPTH)
    ) u_fifo (
        .core_clk_in   (core_clk_in),
        .reset_in      (reset_in),
        .in_data_in    (byte_in),
        .in_valid_in   (byte_valid_in),
        .in_ready_out  (byte_ready_out),
        .out_data_out  (fifo_data),
        .out_valid_out (fifo_valid),
        .out_ready_in  (fifo_pop)
    );

    // fractional divider: 100 MHz does not divide to the bit rate, so
    // tick spacing alternates by one clock while the mean rate is exact
    always_comb begin
        next_acc        = acc + obq_pkg::ACC_INC;
        sample_tick     = (next_acc >= obq_pkg::ACC_MOD);
        if (sample_tick) begin
            next_acc = next_acc - obq_pkg::ACC_MOD;
        end
        next_sample_odd = sample_tick ? ~sample_odd : sample_odd;
        bit_tick        = sample_tick && sample_odd;
    end

    always_ff @(posedge core_clk_in) begin
        if (reset_in) begin
            acc        <= obq_pkg::ACC_RESET;
            sample_odd <= 1'b0;
        end else begin
            acc        <= next_acc;
            sample_odd <= next_sample_odd;
        end
    end

    always_comb begin
        next_shreg      = shreg;
        next_bit_cnt    = bit_cnt;
        next_sreg       = sreg;
        next_pair_state = pair_state;
        next_lead_bit   = lead_bit;
        next_phase      = phase;
        fifo_pop        = 1'b0;
        starved         = 1'b0;
        sym_form        = 1'b0;
        plain_bit       = shreg[7];
        if (bit_tick && bit_cnt == 3'h0) begin
            // link never pauses: an empty fifo sends the fill byte instead
            fifo_pop     = 1'b1;
            starved      = !fifo_valid;
            plain_bit    = fifo_valid ? fifo_data[7] : obq_pkg::FILL_BYTE[7];
            next_shreg   = fifo_valid ? {fifo_data[6:0], 1'b0}
                                      : {obq_pkg::FILL_BYTE[6:0], 1'b0};
            next_bit_cnt = obq_pkg::BIT_CNT_LOAD;
        end else if (bit_tick) begin
            next_shreg   = {shreg[6:0], 1'b0};
            next_bit_cnt = bit_cnt - 3'h1;
        end
        // multiply by x^6, divide by x^6 + x^5 + 1
        scr_bit = plain_bit ^ sreg[obq_pkg::SCR_TAP_A] ^ sreg[obq_pkg::SCR_TAP_B];
        if (bit_tick) begin
            next_sreg = {sreg[4:0], scr_bit};
            case (pair_state)
                obq_pkg::OBQ_PAIR_LEAD: begin
                    next_lead_bit   = scr_bit;
                    next_pair_state = obq_pkg::OBQ_PAIR_TRAIL;
                end
                obq_pkg::OBQ_PAIR_TRAIL: begin
                    next_phase      = phase + obq_pkg::phase_step(lead_bit, scr_bit);
                    sym_form        = 1'b1;
                    next_pair_state = obq_pkg::OBQ_PAIR_LEAD;
                end
                default: begin
                    next_pair_state = obq_pkg::OBQ_PAIR_LEAD;
                end
            endcase
        end
        new_iq = obq_pkg::phase_to_iq(next_phase);
    end

    always_ff @(posedge core_clk_in) begin
        if (reset_in) begin
            shreg             <= 8'h00;
            bit_cnt           <= 3'h0;
            sreg              <= obq_pkg::SCR_RESET;
            pair_state        <= obq_pkg::OBQ_PAIR_LEAD;
            lead_bit          <= 1'b0;
            phase             <= obq_pkg::PHASE_RESET;
            scrambled_bit_out <= 1'b0;
            bit_valid_out     <= 1'b0;
            underrun_out      <= 1'b0;
            i_bit_out         <= 1'b0;
            q_bit_out         <= 1'b0;
            i_level_out       <= 2'sh0;
            q_level_out       <= 2'sh0;
            symbol_valid_out  <= 1'b0;
        end else begin
            shreg             <= next_shreg;
            bit_cnt           <= next_bit_cnt;
            sreg              <= next_sreg;
            pair_state        <= next_pair_state;
            lead_bit          <= next_lead_bit;
            phase             <= next_phase;
            scrambled_bit_out <= bit_tick ? scr_bit : scrambled_bit_out;
            bit_valid_out     <= bit_tick;
            underrun_out      <= starved;
            symbol_valid_out  <= sym_form;
            if (sym_form) begin
                i_bit_out   <= new_iq[1];
                q_bit_out   <= new_iq[0];
                i_level_out <= new_iq[1] ? 2'sh1 : 2'sh3;
                q_level_out <= new_iq[0] ? 2'sh1 : 2'sh3;
            end
        end
    end

    // each tap holds {nonzero, positive}; the symbol enters as one impulse
    // per four samples so the filter needs adders only, no multipliers
    assign next_taps[0] = !sample_tick ? taps[0] :
                          sym_form ? {1'b1, new_iq[1]} : 2'h0;
    genvar g;
    generate
        for (g = 1; g < NT; g++) begin : g_shift
            assign next_taps[g] = sample_tick ? taps[g-1] : taps[g];
        end
    endgenerate

    // q impulse sits beside i; kept in a second line of its own
    logic [1:0] qtaps [0:NT-1];
    logic [1:0] next_qtaps [0:NT-1];
    assign next_qtaps[0] = !sample_tick ? qtaps[0] :
                           sym_form ? {1'b1, new_iq[0]} : 2'h0;
    generate
        for (g = 1; g < NT; g++) begin : g_qshift
            assign next_qtaps[g] = sample_tick ? qtaps[g-1] : qtaps[g];
        end
    endgenerate

    function automatic logic signed [11:0] tap_term(input logic [1:0] tap,
                                                    input logic signed [7:0] c);
        logic signed [11:0] ext;
        ext = {{4{c[7]}}, c};
        if (!tap[1]) begin
            tap_term = 12'sh000;
        end else begin
            tap_term = tap[0] ? ext : -ext;
        end
    endfunction : tap_term

    always_comb begin
        i_sum = 12'sh000;
        q_sum = 12'sh000;
        for (int k = 0; k < NT; k++) begin
            i_sum = i_sum + tap_term(taps[k], obq_pkg::RRC_COEF[
                    k < obq_pkg::HALF_TAPS ? obq_pkg::HALF_TAPS - k : k - obq_pkg::HALF_TAPS]);
            q_sum = q_sum + tap_term(qtaps[k], obq_pkg::RRC_COEF[
                    k < obq_pkg::HALF_TAPS ? obq_pkg::HALF_TAPS - k : k - obq_pkg::HALF_TAPS]);
        end
    end

    always_ff @(posedge core_clk_in) begin
        if (reset_in) begin
            for (int k = 0; k < NT; k++) begin
                taps[k]  <= 2'h0;
                qtaps[k] <= 2'h0;
            end
            i_sample_out     <= 12'sh000;
            q_sample_out     <= 12'sh000;
            sample_valid_out <= 1'b0;
        end else begin
            for (int k = 0; k < NT; k++) begin
                taps[k]  <= next_taps[k];
                qtaps[k] <= next_qtaps[k];
            end
            sample_valid_out <= sample_tick;
            if (sample_tick) begin
                i_sample_out <= i_sum;
                q_sample_out <= q_sum;
            end
        end
    end

    // checking helpers: observed output history and last loaded byte
    logic [5:0] seen_hist;
    logic       plain_q;
    logic [7:0] loaded_byte;
    logic [1:0] prev_iq;
    always_ff @(posedge core_clk_in) begin
        if (reset_in) begin
            seen_hist   <= 6'h00;
            plain_q     <= 1'b0;
            loaded_byte <= 8'h00;
            prev_iq     <= 2'h3;
        end else begin
            if (bit_valid_out) begin
                seen_hist <= {seen_hist[4:0], scrambled_bit_out};
            end
            if (bit_tick) begin
                plain_q <= plain_bit;
            end
            if (fifo_pop) begin
                loaded_byte <= fifo_valid ? fifo_data : obq_pkg::FILL_BYTE;
            end
            if (symbol_valid_out) begin
                prev_iq <= {i_bit_out, q_bit_out};
            end
        end
    end

    property p_bit_spacing;
        @(posedge core_clk_in) disable iff (reset_in)
        bit_tick |-> ##1 (!bit_tick)[*8] ##[24:26] bit_tick;
    endproperty
    a_bit_spacing: assert property (p_bit_spacing)
        else $error("bit enable spacing off the 3.088 MHz rate");

    property p_scramble;
        @(posedge core_clk_in) disable iff (reset_in)
        bit_valid_out |-> scrambled_bit_out == (plain_q ^ seen_hist[4] ^ seen_hist[5]);
    endproperty
    a_scramble: assert property (p_scramble)
        else $error("scrambled bit does not follow x^6+x^5+1");

    property p_every_bit;
        @(posedge core_clk_in) disable iff (reset_in)
        bit_tick |=> bit_valid_out && sreg[0] == scrambled_bit_out;
    endproperty
    a_every_bit: assert property (p_every_bit)
        else $error("bit left the path without passing the scrambler");

    property p_msb_first;
        @(posedge core_clk_in) disable iff (reset_in)
        (bit_tick && bit_cnt != 3'h0) |-> plain_bit == loaded_byte[bit_cnt - 3'h1];
    endproperty
    a_msb_first: assert property (p_msb_first)
        else $error("serial order is not msb first");

    property p_pairing;
        @(posedge core_clk_in) disable iff (reset_in)
        symbol_valid_out |-> ##1 (!symbol_valid_out)[*8] ##[55:60] symbol_valid_out;
    endproperty
    a_pairing: assert property (p_pairing)
        else $error("symbol not formed from every second bit");

    property p_lead_first;
        @(posedge core_clk_in) disable iff (reset_in)
        (bit_tick && pair_state == obq_pkg::OBQ_PAIR_LEAD) |=> lead_bit == $past(scr_bit);
    endproperty
    a_lead_first: assert property (p_lead_first)
        else $error("leading bit is not the first of the pair");

    property p_phase_step;
        @(posedge core_clk_in) disable iff (reset_in)
        sym_form |=> phase == $past(phase) + obq_pkg::phase_step($past(lead_bit), $past(scr_bit));
    endproperty
    a_phase_step: assert property (p_phase_step)
        else $error("phase change does not match the pair");

    property p_iq_levels;
        @(posedge core_clk_in) disable iff (reset_in)
        symbol_valid_out |-> {i_bit_out, q_bit_out} == obq_pkg::phase_to_iq(phase)
            && i_level_out == (i_bit_out ? 2'sh1 : 2'sh3) && q_level_out == (q_bit_out ? 2'sh1 : 2'sh3);
    endproperty
    a_iq_levels: assert property (p_iq_levels)
        else $error("i/q output disagrees with phase or level");

    property p_gray;
        @(posedge core_clk_in) disable iff (reset_in)
        (symbol_valid_out && phase[0] != $past(phase[0], 3))
            |-> $countones({i_bit_out, q_bit_out} ^ prev_iq) == 1;
    endproperty
    a_gray: assert property (p_gray)
        else $error("quarter-turn step changed both i and q");

    property p_reset_clear;
        @(posedge core_clk_in)
        reset_in |=> phase == 2'h0 && sreg == 6'h00 && pair_state == obq_pkg::OBQ_PAIR_LEAD;
    endproperty
    a_reset_clear: assert property (p_reset_clear)
        else $error("reset did not clear phase, scrambler and pairing");

    property p_shaping;
        @(posedge core_clk_in) disable iff (reset_in)
        sym_form |=> taps[0][1] && !taps[1][1] && taps[0][0] == i_bit_out
            && qtaps[0][1] && qtaps[0][0] == q_bit_out;
    endproperty
    a_shaping: assert property (p_shaping)
        else $error("symbol impulse not entered into the shaping filter");

    c_underrun: cover property (@(posedge core_clk_in) disable iff (reset_in) underrun_out);
    c_half_turn: cover property (@(posedge core_clk_in) disable iff (reset_in)
        sym_form && lead_bit && scr_bit);
    c_fifo_full: cover property (@(posedge core_clk_in) disable iff (reset_in)
        byte_valid_in && !byte_ready_out);
endmodule : obq_encoder

// ===== obq_encoder_tb.sv
// testbench: corner and random bytes through the encoder, checked at bit, symbol and receiver
// assumes obq_rx_model on the i/q side; inputs change on the falling edge
`timescale 1ns/1ps
module obq_encoder_tb;
    logic              core_clk_in;
    logic              reset_in;
    logic [7:0]        byte_in;
    logic              byte_valid_in;
    logic              byte_ready_out;
    logic              scrambled_bit_out, bit_valid_out, underrun_out;
    logic              i_bit_out, q_bit_out, symbol_valid_out;
    logic signed [1:0] i_level_out, q_level_out;
    logic signed [11:0] i_sample_out, q_sample_out;
    logic              sample_valid_out, sym;
    int                li [17], lq [17], si, sq;
    logic [1:0]        pair_out, phase, e;
    logic              pair_valid_out, lead, y, x0, x1;
    logic [5:0]        hist;
    logic [7:0]        corner [5] = '{8'h00, 8'hFF, 8'h80, 8'h01, 8'hA5};
    int                n_mismatch, tests_run, cycles, gap, n_bits, n, r;
    bit                exp_q [$];
    bit                rx_q [$];

    obq_encoder i_dut (.core_clk_in(core_clk_in), .reset_in(reset_in), .byte_in(byte_in),
        .byte_valid_in(byte_valid_in), .byte_ready_out(byte_ready_out),
        .scrambled_bit_out(scrambled_bit_out), .bit_valid_out(bit_valid_out),
        .underrun_out(underrun_out), .i_bit_out(i_bit_out), .q_bit_out(q_bit_out),
        .i_level_out(i_level_out), .q_level_out(q_level_out),
        .symbol_valid_out(symbol_valid_out), .i_sample_out(i_sample_out),
        .q_sample_out(q_sample_out), .sample_valid_out(sample_valid_out));
    obq_rx_model i_rx (.core_clk_in(core_clk_in), .reset_in(reset_in), .i_bit_in(i_bit_out),
        .q_bit_in(q_bit_out), .symbol_valid_in(symbol_valid_out), .pair_out(pair_out),
        .pair_valid_out(pair_valid_out));

    function automatic logic [1:0] iq_of(input logic [1:0] p);
        case (p)
            2'h0:    iq_of = 2'h3;
            2'h1:    iq_of = 2'h1;
            2'h2:    iq_of = 2'h0;
            default: iq_of = 2'h2;
        endcase
    endfunction : iq_of

    task automatic check(input logic [11:0] seen, input logic [11:0] want);
        tests_run++;
        if (seen !== want) begin
            n_mismatch++;
            $display("Error at %0t: seen %0h expected %0h", $time, seen, want);
        end
    endtask : check

    task automatic report_and_stop;
        $display("checks %0d mismatches %0d", tests_run, n_mismatch);
        if (n_mismatch == 0 && tests_run > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask : report_and_stop

    // entered at a falling edge; valid is left high so bursts run back to back
    task automatic push(input logic [7:0] b);
        byte_in       = b;
        byte_valid_in = 1'b1;
        while (byte_ready_out !== 1'b1) @(negedge core_clk_in);
        @(posedge core_clk_in);
        for (int k = 7; k >= 0; k--) exp_q.push_back(b[k]);
        @(negedge core_clk_in);
    endtask : push

    task automatic wait_underrun;
        int t;
        t = 0;
        while (underrun_out !== 1'b1 && t < 9000) begin
            @(negedge core_clk_in);
            t++;
        end
        check(t < 9000, 1'b1);
    endtask : wait_underrun

    initial begin
        core_clk_in = 1'b0;
        forever #5 core_clk_in = ~core_clk_in;
    end

    always @(posedge core_clk_in) begin
        cycles++;
        if (cycles == 90000) begin
            n_mismatch++;
            report_and_stop();
        end
    end

    // golden scrambler and phase walk, fed from the bytes taken and the fill bytes
    always @(negedge core_clk_in) begin
        if (reset_in) begin
            hist = 6'h00;
            phase = 2'h0;
            lead = 1'b1;
            n_bits = 0;
            exp_q.delete();
            rx_q.delete();
            foreach (li[k]) begin
                li[k] = 0;
                lq[k] = 0;
            end
        end else begin
            gap++;
            sym = 1'b0;
            if (underrun_out === 1'b1) repeat (8) exp_q.push_back(1'b0);
            if (bit_valid_out === 1'b1) begin
                if (n_bits > 0) check(gap >= 32 && gap <= 34, 1'b1);
                gap = 0;
                n_bits++;
                x0 = (exp_q.size() > 0) ? exp_q.pop_front() : 1'bx;
                y = x0 ^ hist[4] ^ hist[5];
                rx_q.push_back(x0);
                check(scrambled_bit_out, y);
                check(symbol_valid_out, !lead);
                if (!lead) begin
                    sym = 1'b1;
                    phase = phase + (hist[0] ? (y ? 2'h2 : 2'h3) : (y ? 2'h1 : 2'h0));
                    e = iq_of(phase);
                    check({i_bit_out, q_bit_out}, e);
                    check({i_level_out, q_level_out}, {e[1] ? 2'h1 : 2'h3, e[0] ? 2'h1 : 2'h3});
                end
                hist = {hist[4:0], y};
                lead = !lead;
            end
            // golden shaping line: one +-1 impulse per symbol, zeros at the three samples between symbols
            if (sample_valid_out === 1'b1) begin
                si = 0;
                sq = 0;
                for (int k = 0; k < obq_pkg::NUM_TAPS; k++) begin
                    si += li[k] * obq_pkg::RRC_COEF[k < 8 ? 8 - k : k - 8];
                    sq += lq[k] * obq_pkg::RRC_COEF[k < 8 ? 8 - k : k - 8];
                end
                check(i_sample_out, 12'(si));
                check(q_sample_out, 12'(sq));
                for (int k = obq_pkg::NUM_TAPS - 1; k > 0; k--) begin
                    li[k] = li[k-1];
                    lq[k] = lq[k-1];
                end
                li[0] = sym ? (e[1] ? 1 : -1) : 0;
                lq[0] = sym ? (e[0] ? 1 : -1) : 0;
            end
            if (pair_valid_out === 1'b1) begin
                x0 = (rx_q.size() > 0) ? rx_q.pop_front() : 1'bx;
                x1 = (rx_q.size() > 0) ? rx_q.pop_front() : 1'bx;
                check(pair_out, {x0, x1});
            end
        end
    end

    initial begin
        r = $urandom(32'h3ef1a9fc);
        reset_in = 1'b1;
        byte_in = 8'h00;
        byte_valid_in = 1'b0;
        repeat (4) @(negedge core_clk_in);
        reset_in <= 1'b0;
        for (r = 0; r < 9; r++) begin
            wait_underrun();
            if (r == 5) begin
                // mid-run reset: the golden model restarts from zero state as well
                reset_in <= 1'b1;
                repeat (2) @(negedge core_clk_in);
                check(byte_ready_out, 1'b0);
                reset_in <= 1'b0;
                wait_underrun();
            end
            n = 0;
            if (r == 0) begin
                foreach (corner[k]) push(corner[k]);
            end else if (r == 1) begin
                while (byte_ready_out === 1'b1 && n < 20) begin
                    push(8'($urandom));
                    n++;
                end
                check(n >= 16, 1'b1);
                check(byte_ready_out, 1'b0);
            end else begin
                repeat ($urandom_range(1, 6)) push(8'($urandom));
            end
            byte_valid_in = 1'b0;
        end
        wait_underrun();
        repeat (4) @(negedge core_clk_in);
        report_and_stop();
    end
endmodule : obq_encoder_tb

// ===== obq_fifo.sv
// module: synchronous fifo with valid/ready on both sides
// assumes depth is a power of two and one clock with synchronous reset
`timescale 1ns/1ps
module obq_fifo #(
    parameter int WIDTH = obq_pkg::FIFO_WIDTH,
    parameter int DEPTH = obq_pkg::FIFO_DEPTH
) (
    input  wire logic             core_clk_in,
    input  wire logic             reset_in,
    input  wire logic [WIDTH-1:0] in_data_in,
    input  wire logic             in_valid_in,
    output logic                  in_ready_out,
    output logic [WIDTH-1:0]      out_data_out,
    output logic                  out_valid_out,
    input  wire logic             out_ready_in
);
    localparam int AW = $clog2(DEPTH);
    localparam int CW = $clog2(DEPTH + 1);

    logic [WIDTH-1:0] mem [0:DEPTH-1];
    logic [AW-1:0]    wr_ptr;
    logic [AW-1:0]    rd_ptr;
    logic [CW-1:0]    count;
    logic [AW-1:0]    next_wr_ptr;
    logic [AW-1:0]    next_rd_ptr;
    logic [CW-1:0]    next_count;
    logic             next_in_ready;
    logic             push;
    logic             pop;

    assign out_valid_out = (count != '0);
    assign out_data_out  = mem[rd_ptr];

    always_comb begin
        push          = in_valid_in && in_ready_out;
        pop           = out_valid_out && out_ready_in;
        next_wr_ptr   = push ? wr_ptr + AW'(1) : wr_ptr;
        next_rd_ptr   = pop ? rd_ptr + AW'(1) : rd_ptr;
        next_count    = count + CW'(push) - CW'(pop);
        // ready is registered so the source sees a clean level
        next_in_ready = (next_count != CW'(DEPTH));
    end

    always_ff @(posedge core_clk_in) begin
        if (reset_in) begin
            wr_ptr       <= '0;
            rd_ptr       <= '0;
            count        <= '0;
            in_ready_out <= 1'b0;
        end else begin
            wr_ptr       <= next_wr_ptr;
            rd_ptr       <= next_rd_ptr;
            count        <= next_count;
            in_ready_out <= next_in_ready;
        end
    end

    always_ff @(posedge core_clk_in) begin
        if (push) begin
            mem[wr_ptr] <= in_data_in;
        end
    end
endmodule : obq_fifo

// ===== obq_pkg.sv
// package: constants, types and decode functions of the out-of-band path qpsk encoder
// assumes a single 100 MHz core clock and a synchronous active-high reset
package obq_pkg;
    localparam int unsigned CLK_RATE_KHZ       = 100000;
    localparam int unsigned BIT_RATE_KHZ       = 3088;
    localparam int unsigned SAMPLES_PER_SYMBOL = 4;
    localparam int unsigned BITS_PER_SYMBOL    = 2;
    // filter sample rate; every second sample enable is a bit enable
    localparam int unsigned SAMPLE_RATE_KHZ    =
        BIT_RATE_KHZ * SAMPLES_PER_SYMBOL / BITS_PER_SYMBOL;
    localparam int          ACC_W              = 18;
    localparam logic [17:0] ACC_MOD            = 18'(CLK_RATE_KHZ);
    localparam logic [17:0] ACC_INC            = 18'(SAMPLE_RATE_KHZ);
    localparam logic [17:0] ACC_RESET          = 18'h00000;

    localparam int          FIFO_WIDTH         = 8;
    localparam int          FIFO_DEPTH         = 16;
    localparam logic [7:0]  FILL_BYTE          = 8'h00;
    localparam logic [2:0]  BIT_CNT_LOAD       = 3'h7;

    localparam int          SCR_LEN            = 6;
    localparam int          SCR_TAP_A          = 4;
    localparam int          SCR_TAP_B          = 5;
    localparam logic [5:0]  SCR_RESET          = 6'h00;
    localparam logic [1:0]  PHASE_RESET        = 2'h0;

    localparam int          NUM_TAPS           = 17;
    localparam int          HALF_TAPS          = 8;
    localparam int          SAMPLE_W           = 12;
    // root raised cosine, roll-off 0.30, 4 samples per symbol, centre scaled to 127
    localparam logic signed [7:0] RRC_COEF [0:8] = '{
        8'sh7F, 8'sh70, 8'sh48, 8'sh1A, 8'shF7, 8'shE9, 8'shEE, 8'shFC, 8'sh07};

    typedef enum logic {OBQ_PAIR_LEAD, OBQ_PAIR_TRAIL} obq_pair_state_t;

    // pair {a,b} to phase step in quarter turns: a gray-to-binary decode
    function automatic logic [1:0] phase_step(input logic a, input logic b);
        phase_step = {a, a ^ b};
    endfunction : phase_step

    // absolute phase (quarter turns from 45 deg) to {i,q}
    function automatic logic [1:0] phase_to_iq(input logic [1:0] phase);
        case (phase)
            2'h0:    phase_to_iq = 2'h3;
            2'h1:    phase_to_iq = 2'h1;
            2'h2:    phase_to_iq = 2'h0;
            default: phase_to_iq = 2'h2;
        endcase
    endfunction : phase_to_iq
endpackage : obq_pkg

// ===== obq_rx_model.sv
// model: far-end receiver, differential qpsk decode then self-synchronizing descrambler
// assumes i/q bits with a one-cycle symbol strobe from the encoder, same clock and reset
`timescale 1ns/1ps
module obq_rx_model (
    input  wire logic       core_clk_in,
    input  wire logic       reset_in,
    input  wire logic       i_bit_in,
    input  wire logic       q_bit_in,
    input  wire logic       symbol_valid_in,
    output logic [1:0]      pair_out,
    output logic            pair_valid_out
);
    logic [1:0] phase;
    logic [1:0] cur;
    logic [1:0] step;
    logic [5:0] hist;
    logic       a;
    logic       b;
    always_comb begin
        cur  = {~q_bit_in, i_bit_in ^ q_bit_in};
        step = cur - phase;
        a    = step[1];
        b    = step[1] ^ step[0];
    end
    // no seed is shared: the history fills from received bits only
    always_ff @(posedge core_clk_in) begin
        if (reset_in) begin
            phase          <= 2'h0;
            hist           <= 6'h00;
            pair_out       <= 2'h0;
            pair_valid_out <= 1'b0;
        end else begin
            pair_valid_out <= symbol_valid_in;
            if (symbol_valid_in) begin
                phase    <= cur;
                hist     <= {hist[3:0], a, b};
                pair_out <= {a ^ hist[4] ^ hist[5], b ^ hist[3] ^ hist[4]};
            end
        end
    end
endmodule : obq_rx_model
